// [rtl/reset_cause_and_nmi_control.sv]
// Reset-cause recorder, NMI control and regulator sleep control.
// Assumes event inputs are synchronous pulses on clk from local logic,
// the pin input is asynchronous, and nrst is the power-on reset.
`timescale 1ns/10ps
module reset_cause_and_nmi_control import rst_nmi_pkg::*; (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// AXI4-Lite write address
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Reset sources
	input wire logic masterClearPinN,
	input wire logic brownoutEvent,
	input wire logic cfgMismatchEvent,
	input wire logic watchdogTimeout,
	input wire logic deepSleepWake,
	input wire logic inSleep,
	input wire logic inIdle,
	input wire logic wakeEvent,
	input wire logic systemUnlocked,
	input wire logic softwareResetTrigger,
	// NMI sources
	input wire logic generalNmiEvent,
	input wire logic lowVoltageEvent,
	input wire logic clockFailEvent,
	input wire logic nmiKeyWrite,
	input wire logic [7:0] nmiKeyField,
	// Outputs
	output logic masterResetSignal,
	output logic nmiRequest,
	output logic sleepWake,
	output logic regulatorActiveInSleep
);

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	logic pinMeta_q; // First stage, read only by the second
	logic pinSync_q;
	logic pinPrev_q;
	logic pinReset; // Falling edge of the pin

	// Two flops before the pin is used
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_q <= 1'b1;
			pinSync_q <= 1'b1;
			pinPrev_q <= 1'b1;
		end else if (ce) begin
			pinMeta_q <= masterClearPinN;
			pinSync_q <= pinMeta_q;
			pinPrev_q <= pinSync_q;
		end
	end

	assign pinReset = pinPrev_q && !pinSync_q;

	// ----------------------------------------
	// Bus write channel
	// ----------------------------------------
	logic awHeld_q;
	logic [11:0] awAddr_q;
	logic wHeld_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wrFire; // Both halves held and response slot free
	logic [11:0] wrAddr;
	logic [1:0] wrKind;
	logic wrBase; // Low two address bits are zero (word aligned)
	logic selCause;
	logic selNmi;
	logic selPower;
	logic wrHit;

	// Address and data are taken in either order
	assign awready = !awHeld_q && !bvalid_q;
	assign wready = !wHeld_q && !bvalid_q;
	assign wrFire = awHeld_q && wHeld_q && !bvalid_q;
	assign wrAddr = awAddr_q;
	assign wrKind = wrAddr[3:2];
	assign wrBase = (wrAddr[1:0] == 2'h0);
	assign selCause = wrBase && ({wrAddr[11:4], 4'h0} == OFF_RESET_CAUSE);
	assign selNmi = wrBase && ({wrAddr[11:4], 4'h0} == OFF_NMI_CONTROL);
	assign selPower = wrBase &&
		({wrAddr[11:4], 4'h0} == OFF_POWER_CONTROL);
	assign wrHit = selCause || selNmi || selPower;

	// Capture address and data, then answer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			awHeld_q <= 1'b0;
			awAddr_q <= 12'h000;
			wHeld_q <= 1'b0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			if (wvalid && wready) begin
				wHeld_q <= 1'b1;
				wData_q <= wdata;
				wStrb_q <= wstrb;
			end
			if (wrFire) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid_q <= 1'b1;
				// Unmapped addresses get a slave error
				bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// ----------------------------------------
	// Software write bits that raise events
	// ----------------------------------------
	logic [31:0] lane;
	logic [31:0] nmiOnes; // Bits that the write makes one
	logic [31:0] nmiCur;
	logic [31:0] nmiNew;
	logic swWdogNmi;
	logic swSleepNmi;
	logic swClockNmi;
	logic swGeneralNmi;
	logic swTriggerNmi;

	assign lane = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}},
		{8{wStrb_q[0]}}};
	// Rising bits after the alias op decide the software triggers
	assign nmiNew = (wrKind == ALIAS_SET) ? (nmiCur | (wData_q & lane)) :
		(wrKind == ALIAS_INVERT) ? (nmiCur ^ (wData_q & lane)) :
		(wrKind == ALIAS_CLEAR) ? (nmiCur & ~(wData_q & lane)) :
		((nmiCur & ~lane) | (wData_q & lane));
	assign nmiOnes = (wrFire && selNmi) ? (nmiNew & ~nmiCur) : 32'h0000_0000;
	assign swWdogNmi = nmiOnes[NC_WATCHDOG];
	assign swSleepNmi = nmiOnes[NC_SLEEP_WDOG];
	assign swClockNmi = nmiOnes[NC_CLOCK_FAIL];
	assign swGeneralNmi = nmiOnes[NC_GENERAL];
	assign swTriggerNmi = nmiOnes[NC_SW_TRIGGER];

	// ----------------------------------------
	// Hardware set terms
	// ----------------------------------------
	logic wdogAwake; // Watchdog time-out outside sleep
	logic wdogAsleep; // Watchdog time-out during sleep
	logic keyHit;
	logic swResetTaken;
	logic nmiExpire;
	logic [31:0] causeSet;
	logic [31:0] nmiSet;
	logic powerOnSeen_q; // One cycle pulse after power-on release

	assign wdogAwake = watchdogTimeout && !inSleep;
	assign wdogAsleep = watchdogTimeout && inSleep;
	assign keyHit = nmiKeyWrite && (nmiKeyField == NMI_KEY_VALUE);
	// A locked system ignores the software reset trigger
	assign swResetTaken = softwareResetTrigger && systemUnlocked;

	always_comb begin
		causeSet = 32'h0000_0000;
		causeSet[RC_CFG_MISMATCH] = cfgMismatchEvent;
		causeSet[RC_EXT_PIN] = pinReset;
		causeSet[RC_SOFTWARE] = swResetTaken;
		causeSet[RC_WATCHDOG] = nmiExpire;
		causeSet[RC_SLEEP] = inSleep && (wakeEvent || wdogAsleep);
		causeSet[RC_IDLE] = inIdle && wakeEvent;
		causeSet[RC_BROWNOUT] = brownoutEvent;
		causeSet[RC_POWER_ON] = powerOnSeen_q;
		causeSet[RC_DEEP_SLEEP] = deepSleepWake;
	end

	always_comb begin
		nmiSet = 32'h0000_0000;
		nmiSet[NC_WATCHDOG] = wdogAwake;
		nmiSet[NC_GENERAL] = generalNmiEvent || keyHit;
		nmiSet[NC_VOLT_DETECT] = lowVoltageEvent;
		nmiSet[NC_CLOCK_FAIL] = clockFailEvent;
		nmiSet[NC_SLEEP_WDOG] = wdogAsleep;
	end

	// Power-on flags also reset to one, this keeps them fresh
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			powerOnSeen_q <= 1'b1;
		end else if (ce) begin
			powerOnSeen_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] causeVal;
	logic [31:0] powerVal;

	// Sticky flags hold until a software write clears them
	alias_reg #(.IMPL(RC_IMPL_MASK), .RSTV(RC_RESET_VAL)) u_cause (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.wrEn(wrFire && selCause),
		.wrKind(wrKind),
		.wrData(wData_q),
		.wrStrb(wStrb_q),
		.hwSet(causeSet),
		.value(causeVal)
	);

	alias_reg #(.IMPL(NC_IMPL_MASK), .RSTV(NC_RESET_VAL)) u_nmi (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.wrEn(wrFire && selNmi),
		.wrKind(wrKind),
		.wrData(wData_q),
		.wrStrb(wStrb_q),
		.hwSet(nmiSet),
		.value(nmiCur)
	);

	alias_reg #(.IMPL(PC_IMPL_MASK), .RSTV(PC_RESET_VAL)) u_power (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.wrEn(wrFire && selPower),
		.wrKind(wrKind),
		.wrData(wData_q),
		.wrStrb(wStrb_q),
		.hwSet(32'h0000_0000),
		.value(powerVal)
	);

	// ----------------------------------------
	// NMI reset counter
	// ----------------------------------------
	logic cntPending;
	logic cntStart;
	logic nmiReq_q;
	logic wakeReq_q;

	// Only awake watchdog and clock-fail events, or software setting their flags, arm the counter
	assign cntPending = nmiCur[NC_WATCHDOG] || nmiCur[NC_CLOCK_FAIL];
	assign cntStart = (wdogAwake && !nmiCur[NC_WATCHDOG]) ||
		(clockFailEvent && !nmiCur[NC_CLOCK_FAIL]) ||
		swWdogNmi || swClockNmi;

	nmi_reset_counter u_cnt (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.start(cntStart),
		.pending(cntPending),
		.reload(nmiCur[NC_COUNT_LSB +: 16]),
		.expire(nmiExpire)
	);

	// ----------------------------------------
	// NMI, wake and reset outputs
	// ----------------------------------------
	// Registered one-cycle pulses for the interrupt controller
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nmiReq_q <= 1'b0;
			wakeReq_q <= 1'b0;
		end else if (ce) begin
			nmiReq_q <= swTriggerNmi || swWdogNmi || swSleepNmi ||
				swClockNmi || swGeneralNmi || wdogAwake ||
				wdogAsleep || generalNmiEvent || keyHit ||
				lowVoltageEvent || clockFailEvent;
			wakeReq_q <= wdogAsleep;
		end
	end

	// Pin, brown-out, config mismatch, software and NMI counter resets join the master reset
	assign masterResetSignal = pinReset || brownoutEvent ||
		cfgMismatchEvent || swResetTaken || nmiExpire;
	assign nmiRequest = nmiReq_q;
	assign sleepWake = wakeReq_q;
	assign regulatorActiveInSleep = powerVal[PC_REG_ACTIVE];

	// ----------------------------------------
	// Bus read channel
	// ----------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rdCause;
	logic rdNmi;
	logic rdPower;

	// Aliases read back the register itself
	assign rdCause = (araddr[1:0] == 2'h0) &&
		({araddr[11:4], 4'h0} == OFF_RESET_CAUSE);
	assign rdNmi = (araddr[1:0] == 2'h0) &&
		({araddr[11:4], 4'h0} == OFF_NMI_CONTROL);
	assign rdPower = (araddr[1:0] == 2'h0) &&
		({araddr[11:4], 4'h0} == OFF_POWER_CONTROL);
	assign arready = !rvalid_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid_q <= 1'b1;
				rdata_q <= rdCause ? causeVal : rdNmi ? nmiCur :
					rdPower ? powerVal : 32'h0000_0000;
				rresp_q <= (rdCause || rdNmi || rdPower) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

endmodule

// [pkg/rst_nmi_pkg.sv]
// Package for the reset-cause and NMI control block.
// Assumes a 32-bit AXI4-Lite register port with word-aligned registers.
package rst_nmi_pkg;

	// ----------------------------------------
	// Register byte offsets (aliases at +4/+8/+C)
	// ----------------------------------------
	localparam logic [11:0] OFF_RESET_CAUSE = 12'h0_040;
	localparam logic [11:0] OFF_NMI_CONTROL = 12'h0_060;
	localparam logic [11:0] OFF_POWER_CONTROL = 12'h0_070;
	localparam logic [1:0] ALIAS_WRITE = 2'h0;
	localparam logic [1:0] ALIAS_CLEAR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INVERT = 2'h3;

	// ----------------------------------------
	// Reset cause field positions
	// ----------------------------------------
	localparam int RC_POWER_ON = 0;
	localparam int RC_BROWNOUT = 1;
	localparam int RC_IDLE = 2;
	localparam int RC_SLEEP = 3;
	localparam int RC_WATCHDOG = 4;
	localparam int RC_SOFTWARE = 6;
	localparam int RC_EXT_PIN = 7;
	localparam int RC_CFG_MISMATCH = 9;
	localparam int RC_DEEP_SLEEP = 10;
	localparam logic [31:0] RC_IMPL_MASK = 32'h0000_06DF;
	localparam logic [31:0] RC_RESET_VAL = 32'h0000_0003;

	// ----------------------------------------
	// NMI control field positions
	// ----------------------------------------
	localparam int NC_COUNT_LSB = 0;
	localparam int NC_SLEEP_WDOG = 16;
	localparam int NC_CLOCK_FAIL = 17;
	localparam int NC_VOLT_DETECT = 18;
	localparam int NC_GENERAL = 19;
	localparam int NC_SW_TRIGGER = 23;
	localparam int NC_WATCHDOG = 24;
	localparam logic [31:0] NC_IMPL_MASK = 32'h018F_FFFF;
	localparam logic [31:0] NC_RESET_VAL = 32'h0000_0000;
	localparam logic [7:0] NMI_KEY_VALUE = 8'h4E;

	// ----------------------------------------
	// Power control
	// ----------------------------------------
	localparam int PC_REG_ACTIVE = 0;
	localparam logic [31:0] PC_IMPL_MASK = 32'h0000_0001;
	localparam logic [31:0] PC_RESET_VAL = 32'h0000_0000;

	// ----------------------------------------
	// AXI responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/alias_reg.sv]
// One software register with write, clear, set and invert aliases.
// Assumes hardware set requests are one-cycle or level terms on clk.
`timescale 1ns/10ps
module alias_reg import rst_nmi_pkg::*; #(
	parameter logic [31:0] IMPL = 32'h0000_0000,
	parameter logic [31:0] RSTV = 32'h0000_0000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Software write
	input wire logic wrEn,
	input wire logic [1:0] wrKind,
	input wire logic [31:0] wrData,
	input wire logic [3:0] wrStrb,
	// Hardware sets
	input wire logic [31:0] hwSet,
	// Current value
	output logic [31:0] value
);

	logic [31:0] val_q;
	logic [31:0] val_d;
	logic [31:0] lane; // Byte lanes expanded to bits
	logic [31:0] swVal; // Value after the software write

	assign lane = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}},
		{8{wrStrb[0]}}};

	// Pick the alias operation
	always_comb begin
		case (wrKind)
			ALIAS_CLEAR: swVal = val_q & ~(wrData & lane);
			ALIAS_SET: swVal = val_q | (wrData & lane);
			ALIAS_INVERT: swVal = val_q ^ (wrData & lane);
			default: swVal = (val_q & ~lane) | (wrData & lane);
		endcase
	end

	// Hardware set wins over a same-cycle software clear
	assign val_d = ((wrEn ? swVal : val_q) | hwSet) & IMPL;

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			val_q <= RSTV;
		end else if (ce) begin
			val_q <= val_d;
		end
	end

	assign value = val_q;

endmodule

// [rtl/nmi_reset_counter.sv]
// Down counter that issues a reset when an armed NMI goes unhandled.
// Assumes pending is a level and start is a one-cycle pulse on clk.
`timescale 1ns/10ps
module nmi_reset_counter (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Control
	input wire logic start,
	input wire logic pending,
	input wire logic [15:0] reload,
	// Result
	output logic expire
);

	logic [15:0] cnt_q;
	logic run_q;
	logic atZero;

	assign atZero = (cnt_q == 16'h0000);

	// Load on a new event, count while pending, stop when cleared
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 16'h0000;
			run_q <= 1'b0;
		end else if (ce) begin
			if (start) begin
				cnt_q <= reload;
				run_q <= 1'b1;
			end else if (!pending) begin
				run_q <= 1'b0;
			end else if (run_q && !atZero) begin
				cnt_q <= cnt_q - 16'h0001;
			end
		end
	end

	// Reset request once the count has run out
	assign expire = run_q && pending && atZero;

endmodule

// [tb/rst_nmi_sva.sv]
// Checker of port timing for the reset-cause and NMI block.
// Assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/10ps
module rst_nmi_sva import rst_nmi_pkg::*; (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// Bus answers
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Sources
	input wire logic brownoutEvent,
	input wire logic cfgMismatchEvent,
	input wire logic watchdogTimeout,
	input wire logic inSleep,
	input wire logic systemUnlocked,
	input wire logic softwareResetTrigger,
	input wire logic generalNmiEvent,
	input wire logic lowVoltageEvent,
	input wire logic clockFailEvent,
	input wire logic nmiKeyWrite,
	input wire logic [7:0] nmiKeyField,
	// Results
	input wire logic masterResetSignal,
	input wire logic nmiRequest,
	input wire logic sleepWake
);
	// ----------------------------------------
	// One clock domain, reset disables all
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Answers waiting on the master
	sequence sWaitB;
		bvalid && !bready;
	endsequence
	sequence sWaitR;
		rvalid && !rready;
	endsequence
	// One-cycle NMI pulse
	sequence sNmiPulse;
		nmiRequest ##1 !nmiRequest;
	endsequence
	AST_B_HOLD: assert property (sWaitB |=> bvalid && $stable(bresp))
		else $error("write answer dropped before bready");
	AST_R_HOLD: assert property (sWaitR |=> rvalid && $stable(rdata))
		else $error("read answer dropped before rready");
	AST_RST_BOR: assert property (
		brownoutEvent |-> masterResetSignal)
		else $error("brown-out gave no master reset");
	AST_RST_CFG: assert property (
		cfgMismatchEvent |-> masterResetSignal)
		else $error("config mismatch gave no master reset");
	AST_RST_SW: assert property (
		softwareResetTrigger && systemUnlocked |-> masterResetSignal)
		else $error("software reset lost");
	AST_NMI_GEN: assert property (
		ce && generalNmiEvent |=> sNmiPulse)
		else $error("general event gave no single NMI pulse");
	AST_NMI_LV: assert property (
		ce && lowVoltageEvent |=> nmiRequest)
		else $error("low voltage gave no NMI");
	AST_NMI_CF: assert property (
		ce && clockFailEvent |=> nmiRequest)
		else $error("clock failure gave no NMI");
	AST_NMI_KEY: assert property (
		ce && nmiKeyWrite && nmiKeyField == NMI_KEY_VALUE |=> nmiRequest)
		else $error("key write gave no NMI");
	AST_WAKE: assert property (
		ce && watchdogTimeout && inSleep |=> sleepWake)
		else $error("sleep watchdog gave no wake");
endmodule

bind reset_cause_and_nmi_control rst_nmi_sva i_rst_nmi_sva (.clk, .nrst, .ce,
	.bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .brownoutEvent,
	.cfgMismatchEvent, .watchdogTimeout, .inSleep, .systemUnlocked,
	.softwareResetTrigger, .generalNmiEvent, .lowVoltageEvent, .clockFailEvent,
	.nmiKeyWrite, .nmiKeyField, .masterResetSignal, .nmiRequest, .sleepWake);

// [tb/reset_cause_and_nmi_control_bench.sv]
// Self-checking bench for the reset-cause and NMI block.
// Assumes the block answers every AXI4-Lite request within the bench
// timeout and that event inputs are one-cycle pulses.
`timescale 1ns/10ps
module reset_cause_and_nmi_control_bench import rst_nmi_pkg::*;;
	// ----------------------------------------
	// Stimulus and results
	// ----------------------------------------
	logic clk, nrst, ce, masterClearPinN, inSleep, inIdle, systemUnlocked;
	logic [11:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic [9:0] ev; // One bit per pulsed event input
	logic [7:0] nmiKeyField;
	wire logic awready, wready, bvalid, arready, rvalid;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic masterResetSignal, nmiRequest, sleepWake, regulatorActiveInSleep;
	logic [33:0] rdQ[$]; // Expected {rresp, rdata}
	logic [1:0] wrQ[$]; // Expected bresp
	logic mrstP;
	int errors, checksDone, nmi_reset_count_reload, rstCnt, n, r;
	logic [15:0] rl;
	int rcBit[4] = '{RC_BROWNOUT, RC_CFG_MISMATCH, RC_DEEP_SLEEP, RC_SOFTWARE};

	reset_cause_and_nmi_control i_reset_cause_and_nmi_control (.clk, .nrst,
		.ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .masterClearPinN, .brownoutEvent(ev[0]),
		.cfgMismatchEvent(ev[1]), .watchdogTimeout(ev[8]),
		.deepSleepWake(ev[2]), .inSleep, .inIdle, .wakeEvent(ev[4]),
		.systemUnlocked, .softwareResetTrigger(ev[3]),
		.generalNmiEvent(ev[5]), .lowVoltageEvent(ev[6]),
		.clockFailEvent(ev[7]), .nmiKeyWrite(ev[9]), .nmiKeyField,
		.masterResetSignal, .nmiRequest, .sleepWake, .regulatorActiveInSleep);

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [33:0] e,
		input logic [33:0] s);
		checksDone++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d comparisons %0d", errors, checksDone);
		if (errors == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Monitor: answers are judged against the oldest note
	always @(posedge clk) begin
		if (rvalid && rready)
			chk("read", rdQ.pop_front(), {rresp, rdata});
		if (bvalid && bready)
			chk("bresp", {32'h0, wrQ.pop_front()}, {32'h0, bresp});
		if (nmiRequest)
			nmi_reset_count_reload++;
		if (masterResetSignal && !mrstP)
			rstCnt++;
		mrstP = masterResetSignal;
	end

	// ----------------------------------------
	// Bus master and event tasks
	// ----------------------------------------
	// Each valid drops only at the edge where its ready is seen
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] rs = RESP_OKAY);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wrQ.push_back(rs);
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		// Let an edge pass so the next call never re-drives bready now
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] rs = RESP_OKAY);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rdQ.push_back({rs, d});
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		// Let an edge pass so the next call never re-drives rready now
		@(posedge clk);
	endtask

	// One-cycle pulse on an event input
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
		@(posedge clk);
	endtask

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{nrst, awvalid, wvalid, bready, arvalid, rready, ev} = '0;
		{awaddr, araddr, wdata, nmiKeyField, inSleep, inIdle} = '0;
		{ce, masterClearPinN, systemUnlocked, mrstP} = 4'hE;
		wstrb = 4'hF;
		void'($urandom(32'h3d778a95));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(OFF_RESET_CAUSE, RC_RESET_VAL);
		rd(OFF_NMI_CONTROL, NC_RESET_VAL);
		rd(OFF_POWER_CONTROL, PC_RESET_VAL);
		wr(OFF_RESET_CAUSE, 32'h0);
		rd(OFF_RESET_CAUSE, 32'h0);
		// Reset causes, each cleared through the clear alias
		for (int i = 0; i < 4; i++) begin
			pulse(i);
			rd(OFF_RESET_CAUSE, 32'h1 << rcBit[i]);
			wr(OFF_RESET_CAUSE + 12'h4, 32'hFFFF_FFFF);
		end
		systemUnlocked <= 1'b0;
		pulse(3);
		rd(OFF_RESET_CAUSE, 32'h0);
		// A low clock enable freezes the flags
		ce <= 1'b0;
		pulse(0);
		ce <= 1'b1;
		rd(OFF_RESET_CAUSE, 32'h0);
		for (int j = 0; j < 2; j++) begin
			inSleep <= (j == 0);
			inIdle <= (j == 1);
			pulse(4);
			rd(OFF_RESET_CAUSE, j ? 32'h4 : 32'h8);
			wr(OFF_RESET_CAUSE, 32'h0);
		end
		inIdle <= 1'b0;
		masterClearPinN <= 1'b0;
		repeat (3 + $urandom % 5) @(posedge clk);
		masterClearPinN <= 1'b1;
		repeat (4) @(posedge clk);
		rd(OFF_RESET_CAUSE, 32'h80);
		wr(OFF_RESET_CAUSE, 32'hFFFF_FFFF);
		rd(OFF_RESET_CAUSE, RC_IMPL_MASK);
		wr(OFF_RESET_CAUSE + 12'hC, 32'hFFFF_FFFF);
		rd(OFF_RESET_CAUSE, 32'h0);
		// Regulator control, byte lanes and unmapped space
		wr(OFF_POWER_CONTROL, $urandom | 32'h1);
		rd(OFF_POWER_CONTROL, 32'h1);
		chk("regulator", 34'h1, {33'h0, regulatorActiveInSleep});
		wr(OFF_POWER_CONTROL + 12'hC, 32'h1);
		rd(OFF_POWER_CONTROL, 32'h0);
		chk("regulator", 34'h0, {33'h0, regulatorActiveInSleep});
		// A write without the low byte lane leaves the bit alone
		wstrb <= 4'hE;
		wr(OFF_POWER_CONTROL, 32'h1);
		wstrb <= 4'hF;
		rd(OFF_POWER_CONTROL, 32'h0);
		wr(12'h100, $urandom, RESP_SLVERR);
		rd(12'h100, 32'h0, RESP_SLVERR);
		// NMI sources: four raise one, the wrong key and a zero write none
		n = nmi_reset_count_reload;
		pulse(5);
		pulse(6);
		nmiKeyField <= NMI_KEY_VALUE;
		pulse(9);
		nmiKeyField <= 8'h4F;
		pulse(9);
		rd(OFF_NMI_CONTROL, 32'h000C_0000);
		wr(OFF_NMI_CONTROL + 12'h8, 32'h0080_0000);
		wr(OFF_NMI_CONTROL, 32'h0);
		chk("nmi count", 34'(n + 4), 34'(nmi_reset_count_reload));
		// Counter runs out after a clock failure
		wr(OFF_NMI_CONTROL, 32'h5);
		r = rstCnt;
		n = nmi_reset_count_reload;
		pulse(7);
		// Five decrements after the load edge: still quiet three edges on
		repeat (3) @(posedge clk);
		chk("counter early", 34'(r), 34'(rstCnt));
		repeat (17) @(posedge clk);
		chk("counter reset", 34'(r + 1), 34'(rstCnt));
		chk("clock fail nmi", 34'(n + 1), 34'(nmi_reset_count_reload));
		rd(OFF_NMI_CONTROL, 32'h0002_0005);
		wr(OFF_NMI_CONTROL + 12'h4, 32'hFFFF_FFFF);
		rd(OFF_RESET_CAUSE, 32'h10);
		wr(OFF_RESET_CAUSE, 32'h0);
		// Watchdog NMI cleared in time, then one in sleep
		rl = 16'(100 + $urandom % 200);
		wr(OFF_NMI_CONTROL, {16'h0, rl});
		r = rstCnt;
		pulse(8);
		rd(OFF_NMI_CONTROL, {16'h0100, rl});
		wr(OFF_NMI_CONTROL + 12'h4, 32'h0100_0000);
		inSleep <= 1'b1;
		pulse(8);
		inSleep <= 1'b0;
		rd(OFF_NMI_CONTROL, {16'h0001, rl});
		repeat (400) @(posedge clk);
		chk("no counter reset", 34'(r), 34'(rstCnt));
		rd(OFF_RESET_CAUSE, 32'h8);
		complete_run();
	end
endmodule
